// File: rtl/dasp_pkg.sv
// dasp_pkg: constants and types of the dual asynchronous serial port
// Functional notes
// - write strobe low with select low loads data into the addressed register at strobe rise.
// - read strobe and select both low put the addressed register on the data bus.
// - host gives a four-bit address each access; device decodes it to one register.
// - receiver assembles characters taking the least significant bit first.
// - with external receive clock selected, serial input is sampled on its rising edge.
// - transmitter sends the least significant data bit first.
// - serial output stays high when idle or disabled in normal mode, and in local loopback; echo and remote modes pass the serial input.
// - with external transmit clock selected, the shifter moves on its falling edge.
// - input bit three clocks channel A transmit in strobe style, receive in vectored style.
// - input bits zero and one read as inputs or clear-to-send for channels A and B.
// - stop length is programmable in sixteenths of a bit time with a 16X clock; with an external 1X clock it is one bit time.
// - receivers buffer four characters, transmitters buffer two.
// - every transmitter and receiver picks its own rate, internal or external clock, except that the bus style lets only one side of channel A go external.
// - 1X clock runs to 1 Mb/s, 16X clock to 125 kb/s.
// - each channel has normal, echo, local loopback and remote loopback modes.
// - multi-drop mode adds a ninth bit that marks address characters.
package dasp_pkg;

  localparam logic [2:0] OFS_MODE1   = 3'h0;
  localparam logic [2:0] OFS_MODE2   = 3'h1;
  localparam logic [2:0] OFS_TX_DIV  = 3'h2;
  localparam logic [2:0] OFS_RX_DIV  = 3'h3;
  localparam logic [2:0] OFS_CMD     = 3'h4;
  localparam logic [2:0] OFS_DATA    = 3'h5;
  localparam logic [2:0] OFS_IN_PORT = 3'h6;

  localparam int CMD_TX_ON   = 0;
  localparam int CMD_TX_OFF  = 1;
  localparam int CMD_RX_ON   = 2;
  localparam int CMD_RX_OFF  = 3;
  localparam int CMD_CLR_ERR = 4;

  localparam logic [3:0] BIT_TICKS_M1 = 4'hf;
  localparam logic [3:0] MID_TICK     = 4'h7;
  localparam logic [3:0] BASE_BITS    = 4'h9;
  localparam logic [7:0] DIV_RST      = 8'h0c;

  localparam int TX_W     = 9;
  localparam int RX_W     = 11;
  localparam int TX_DEPTH = 2;
  localparam int RX_DEPTH = 4;

  typedef enum logic [1:0] {
    DASP_NORMAL = 2'b00,
    DASP_ECHO   = 2'b01,
    DASP_LOCAL  = 2'b10,
    DASP_REMOTE = 2'b11
  } dasp_mode_t;

  typedef enum logic [1:0] {
    DASP_TX_IDLE = 2'b00,
    DASP_TX_BITS = 2'b01,
    DASP_TX_STOP = 2'b10
  } dasp_tx_t;

  typedef enum logic {
    DASP_RX_IDLE = 1'b0,
    DASP_RX_BITS = 1'b1
  } dasp_rx_t;

  typedef struct packed {
    logic       ext_1x;
    logic       cts_en;
    logic       tx_addr_bit;
    logic       multidrop;
    logic       par_odd;
    logic       par_en;
    dasp_mode_t chan_mode;
  } dasp_mode1_t;

  typedef struct packed {
    logic [1:0] spare;
    logic       rx_ext;
    logic       tx_ext;
    logic [3:0] stop_extra;
  } dasp_mode2_t;

  typedef struct packed {
    dasp_mode1_t m1;
    dasp_mode2_t m2;
    logic [7:0]  tx_div;
    logic [7:0]  rx_div;
    logic        tx_en;
    logic        rx_en;
  } dasp_cfg_t;

  typedef struct packed {
    logic rx_addr_char;
    logic frame_err;
    logic parity_err;
    logic overrun;
    logic tx_empty;
    logic tx_ready;
    logic rx_full;
    logic rx_ready;
  } dasp_status_t;

  typedef struct packed {
    logic       frame_err;
    logic       parity_err;
    logic [8:0] data;
  } dasp_rx_word_t;

  typedef struct packed {
    logic       bus_style;
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic [3:0] addr;
    logic [7:0] data;
    logic       ip0;
    logic       ip1;
    logic       ip3;
    logic       rxd_a;
    logic       rxd_b;
    logic       b_rx_clk;
    logic       b_tx_clk;
  } dasp_pins_t;

  localparam dasp_pins_t PINS_RST = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, ip0: 1'b1, ip1: 1'b1,
                                      rxd_a: 1'b1, rxd_b: 1'b1, default: '0};
  localparam dasp_cfg_t  CFG_RST  = '{tx_div: DIV_RST, rx_div: DIV_RST, default: '0};

endpackage

// File: rtl/dasp_top.sv
// dasp_top: parallel host port, two serial channels and their character buffers
module dasp_fifo
  import dasp_pkg::*;
#(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output      logic         in_ready,
  output      logic         out_valid,
  output      logic [W-1:0] out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr_ptr;
    logic [AW-1:0]           rd_ptr;
    logic [CW-1:0]           count;
  } dasp_fifo_st_t;

  dasp_fifo_st_t st_reg;
  dasp_fifo_st_t st_next;
  logic          push;
  logic          pop;

  always_comb begin
    st_next   = st_reg;
    in_ready  = (st_reg.count != CW'(DEPTH));
    out_valid = (st_reg.count != '0);
    out_data  = st_reg.mem[st_reg.rd_ptr];
    push      = in_valid & in_ready;
    pop       = out_valid & out_ready;
    if (push) begin
      st_next.mem[st_reg.wr_ptr] = in_data;
      st_next.wr_ptr             = st_reg.wr_ptr + AW'(1);
    end
    if (pop) begin
      st_next.rd_ptr = st_reg.rd_ptr + AW'(1);
    end
    st_next.count = st_reg.count + CW'(push) - CW'(pop);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

module dasp_chan
  import dasp_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          rst_n,
  input  wire dasp_cfg_t     cfg,
  input  wire logic          tx_push,
  input  wire logic [8:0]    tx_word,
  output      logic          tx_ready,
  output      logic          tx_empty,
  input  wire logic          rx_pop,
  output      logic          rx_valid,
  output      logic          rx_full,
  output      dasp_rx_word_t rx_head,
  output      logic          overrun,
  input  wire logic          clr_err,
  input  wire logic          tx_ext_ok,
  input  wire logic          tx_ext_fall,
  input  wire logic          rx_ext_ok,
  input  wire logic          rx_ext_rise,
  input  wire logic          serial_in,
  input  wire logic          cts_n,
  output      logic          serial_out
);
  typedef struct packed {
    dasp_tx_t    tx_st;
    logic [7:0]  tx_div;
    logic [3:0]  tx_sub;
    logic [3:0]  tx_idx;
    logic [3:0]  tx_nb;
    logic [4:0]  tx_stop;
    logic [11:0] transmit_shifter;
    dasp_rx_t    rx_st;
    logic [7:0]  rx_div;
    logic [3:0]  rx_sub;
    logic [3:0]  rx_idx;
    logic [11:0] rx_bits;
    logic        overrun;
    logic        serial_out;
  } dasp_chan_st_t;

  dasp_chan_st_t st_reg;
  dasp_chan_st_t st_next;
  logic          txq_valid;
  logic [8:0]    txq_data;
  logic          tx_start;
  logic          rxq_ready;
  logic [RX_W-1:0] rxq_data;
  logic          rx_push;
  dasp_rx_word_t rx_word;
  logic          tx_ext;
  logic          rx_ext;
  logic          tx_1x;
  logic          rx_1x;
  logic          tx_tick;
  logic          rx_tick;
  logic          tx_line;
  logic          rx_line;
  logic [3:0]    tx_last;
  logic [3:0]    rx_last;
  logic [3:0]    rx_mid;
  logic [3:0]    rx_nb;
  logic [4:0]    stop_last;
  logic [11:0]   frame;
  logic          par_bit;

  assign rx_head  = dasp_rx_word_t'(rxq_data);
  assign rx_full  = ~rxq_ready;
  assign overrun  = st_reg.overrun;
  assign tx_empty = ~txq_valid & (st_reg.tx_st == DASP_TX_IDLE);
  assign serial_out = st_reg.serial_out;

  always_comb begin
    st_next = st_reg;
    rx_push = 1'b0;
    rx_word = '0;
    frame   = '1;
    // external clocks count only where the pin routing offers one
    tx_ext  = cfg.m2.tx_ext & tx_ext_ok;
    rx_ext  = cfg.m2.rx_ext & rx_ext_ok;
    tx_1x   = tx_ext & cfg.m1.ext_1x;
    rx_1x   = rx_ext & cfg.m1.ext_1x;
    st_next.tx_div = (st_reg.tx_div == 8'h00) ? cfg.tx_div : st_reg.tx_div - 8'h01;
    st_next.rx_div = (st_reg.rx_div == 8'h00) ? cfg.rx_div : st_reg.rx_div - 8'h01;
    tx_tick = tx_ext ? tx_ext_fall : (st_reg.tx_div == 8'h00);
    rx_tick = rx_ext ? rx_ext_rise : (st_reg.rx_div == 8'h00);
    tx_last = tx_1x ? 4'h0 : BIT_TICKS_M1;
    rx_last = rx_1x ? 4'h0 : BIT_TICKS_M1;
    rx_mid  = rx_1x ? 4'h0 : MID_TICK;
    stop_last = tx_1x ? 5'h00 : {1'b0, BIT_TICKS_M1} + {1'b0, cfg.m2.stop_extra};

    // frame: start, data lsb first, address bit, parity
    par_bit   = (^txq_data[7:0]) ^ cfg.m1.par_odd;
    frame[0]  = 1'b0;
    frame[8:1] = txq_data[7:0];
    if (cfg.m1.multidrop) begin
      frame[9] = txq_data[8];
    end
    if (cfg.m1.par_en) begin
      frame[cfg.m1.multidrop ? 10 : 9] = par_bit;
    end
    tx_start = (st_reg.tx_st == DASP_TX_IDLE) & cfg.tx_en & txq_valid & tx_tick
             & (~cfg.m1.cts_en | ~cts_n);
    tx_line  = (st_reg.tx_st == DASP_TX_BITS) & cfg.tx_en ? st_reg.transmit_shifter[0] : 1'b1;

    unique case (st_reg.tx_st)
      DASP_TX_IDLE: begin
        if (tx_start) begin
          st_next.tx_st            = DASP_TX_BITS;
          st_next.transmit_shifter = frame;
          st_next.tx_nb            = BASE_BITS + {3'h0, cfg.m1.multidrop} + {3'h0, cfg.m1.par_en};
          st_next.tx_idx           = 4'h0;
          st_next.tx_sub           = 4'h0;
        end
      end
      DASP_TX_BITS: begin
        if (tx_tick) begin
          if (st_reg.tx_sub == tx_last) begin
            st_next.tx_sub           = 4'h0;
            st_next.transmit_shifter = {1'b1, st_reg.transmit_shifter[11:1]};
            st_next.tx_idx           = st_reg.tx_idx + 4'h1;
            if (st_reg.tx_idx == st_reg.tx_nb - 4'h1) begin
              st_next.tx_st   = DASP_TX_STOP;
              st_next.tx_stop = 5'h00;
            end
          end else begin
            st_next.tx_sub = st_reg.tx_sub + 4'h1;
          end
        end
      end
      DASP_TX_STOP: begin
        if (tx_tick) begin
          if (st_reg.tx_stop == stop_last) begin
            st_next.tx_st = DASP_TX_IDLE;
          end else begin
            st_next.tx_stop = st_reg.tx_stop + 5'h01;
          end
        end
      end
      default: begin
        st_next.tx_st = DASP_TX_IDLE;
      end
    endcase
    if (!cfg.tx_en) begin
      st_next.tx_st = DASP_TX_IDLE;
    end

    // receiver; local loopback feeds it from the transmitter
    rx_line = (cfg.m1.chan_mode == DASP_LOCAL) ? tx_line : serial_in;
    rx_nb   = BASE_BITS + {3'h0, cfg.m1.multidrop} + {3'h0, cfg.m1.par_en};
    unique case (st_reg.rx_st)
      DASP_RX_IDLE: begin
        if (rx_tick & cfg.rx_en & ~rx_line) begin
          st_next.rx_st  = DASP_RX_BITS;
          st_next.rx_sub = rx_1x ? 4'h0 : 4'h1;
          st_next.rx_idx = rx_1x ? 4'h1 : 4'h0;
        end
      end
      DASP_RX_BITS: begin
        if (rx_tick) begin
          st_next.rx_sub = (st_reg.rx_sub == rx_last) ? 4'h0 : st_reg.rx_sub + 4'h1;
          if (st_reg.rx_sub == rx_mid) begin
            st_next.rx_bits[st_reg.rx_idx] = rx_line;
            st_next.rx_idx                 = st_reg.rx_idx + 4'h1;
            if ((st_reg.rx_idx == 4'h0) && rx_line) begin
              st_next.rx_st = DASP_RX_IDLE;
            end else if (st_reg.rx_idx == rx_nb) begin
              st_next.rx_st      = DASP_RX_IDLE;
              rx_word.data[7:0]  = st_reg.rx_bits[8:1];
              rx_word.data[8]    = cfg.m1.multidrop & st_reg.rx_bits[9];
              rx_word.parity_err = cfg.m1.par_en & ((^st_reg.rx_bits[8:1]) ^ cfg.m1.par_odd
                                 ^ st_reg.rx_bits[cfg.m1.multidrop ? 10 : 9]);
              rx_word.frame_err  = ~rx_line;
              rx_push            = (cfg.m1.chan_mode != DASP_REMOTE);
            end
          end
        end
      end
    endcase
    if (!cfg.rx_en) begin
      st_next.rx_st = DASP_RX_IDLE;
    end
    // a new overrun in the clearing cycle survives the clear
    st_next.overrun = (st_reg.overrun & ~clr_err) | (rx_push & ~rxq_ready);

    unique case (cfg.m1.chan_mode)
      DASP_NORMAL: st_next.serial_out = tx_line;
      DASP_ECHO:   st_next.serial_out = serial_in;
      DASP_LOCAL:  st_next.serial_out = 1'b1;
      DASP_REMOTE: st_next.serial_out = serial_in;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg            <= '0;
      st_reg.serial_out <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  dasp_fifo #(.W(TX_W), .DEPTH(TX_DEPTH)) u_tx_q (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_valid  (tx_push),
    .in_data   (tx_word),
    .in_ready  (tx_ready),
    .out_valid (txq_valid),
    .out_data  (txq_data),
    .out_ready (tx_start)
  );

  dasp_fifo #(.W(RX_W), .DEPTH(RX_DEPTH)) u_rx_q (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_valid  (rx_push),
    .in_data   (rx_word),
    .in_ready  (rxq_ready),
    .out_valid (rx_valid),
    .out_data  (rxq_data),
    .out_ready (rx_pop)
  );
endmodule

module dasp_top
  import dasp_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       bus_style,
  input  wire logic       chip_select_n,
  input  wire logic       read_strobe_n,
  input  wire logic       write_strobe_n,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] data_in,
  output      logic [7:0] data_out,
  output      logic       data_oe,
  input  wire logic       input_port_bit0,
  input  wire logic       input_port_bit1,
  input  wire logic       input_port_bit3,
  input  wire logic       chan_a_serial_in,
  input  wire logic       chan_b_serial_in,
  input  wire logic       chan_b_ext_rx_clock,
  input  wire logic       chan_b_ext_tx_clock,
  output      logic       chan_a_serial_out,
  output      logic       chan_b_serial_out
);
  typedef struct packed {
    dasp_pins_t       s1;
    dasp_pins_t       s2;
    dasp_pins_t       s3;
    dasp_pins_t       f;
    dasp_pins_t       fd;
    logic [3:0]       wr_addr;
    logic [7:0]       wr_data;
    logic [3:0]       rd_addr;
    dasp_cfg_t [1:0]  cfg;
    logic [7:0]       data_out;
    logic             data_oe;
  } dasp_top_st_t;

  dasp_top_st_t        st_reg;
  dasp_top_st_t        st_next;
  logic [1:0]          rst_pipe;
  logic                rst_n;
  logic                wr_act;
  logic                wr_prev;
  logic                rd_act;
  logic                rd_prev;
  logic [1:0]          tx_push;
  logic [1:0]          rx_pop;
  logic [1:0]          clr_err;
  logic [1:0]          tx_ready;
  logic [1:0]          tx_empty;
  logic [1:0]          rx_valid;
  logic [1:0]          rx_full;
  logic [1:0]          overrun;
  dasp_rx_word_t [1:0] rx_head;
  dasp_status_t [1:0]  status;
  logic [1:0]          tx_ext_ok;
  logic [1:0]          tx_ext_fall;
  logic [1:0]          rx_ext_ok;
  logic [1:0]          rx_ext_rise;
  logic [1:0]          serial_in;
  logic [1:0]          cts_n;
  logic [1:0]          serial_out;
  logic                wch;
  logic                rch;

  // reset leaves through two flops
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  assign data_out          = st_reg.data_out;
  assign data_oe           = st_reg.data_oe;
  assign chan_a_serial_out = serial_out[0];
  assign chan_b_serial_out = serial_out[1];

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = '{bus_style, chip_select_n, read_strobe_n, write_strobe_n, reg_addr, data_in,
                   input_port_bit0, input_port_bit1, input_port_bit3, chan_a_serial_in,
                   chan_b_serial_in, chan_b_ext_rx_clock, chan_b_ext_tx_clock};
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    // a pin change is taken once the second and third stages agree
    st_next.f  = dasp_pins_t'((st_reg.s2 & st_reg.s3) | (st_reg.f & (st_reg.s2 ^ st_reg.s3)));
    st_next.fd = st_reg.f;
    tx_push    = 2'b00;
    rx_pop     = 2'b00;
    clr_err    = 2'b00;

    // channel A clock pin depends on the bus style strap
    tx_ext_ok   = {1'b1, ~st_reg.f.bus_style};
    rx_ext_ok   = {1'b1, st_reg.f.bus_style};
    tx_ext_fall = {st_reg.fd.b_tx_clk & ~st_reg.f.b_tx_clk, st_reg.fd.ip3 & ~st_reg.f.ip3};
    rx_ext_rise = {~st_reg.fd.b_rx_clk & st_reg.f.b_rx_clk, ~st_reg.fd.ip3 & st_reg.f.ip3};
    serial_in   = {st_reg.f.rxd_b, st_reg.f.rxd_a};
    cts_n       = {st_reg.f.ip1, st_reg.f.ip0};

    wr_act  = ~st_reg.f.cs_n & ~st_reg.f.wr_n;
    wr_prev = ~st_reg.fd.cs_n & ~st_reg.fd.wr_n;
    rd_act  = ~st_reg.f.cs_n & ~st_reg.f.rd_n;
    rd_prev = ~st_reg.fd.cs_n & ~st_reg.fd.rd_n;
    if (wr_act) begin
      st_next.wr_addr = st_reg.f.addr;
      st_next.wr_data = st_reg.f.data;
    end
    if (rd_act) begin
      st_next.rd_addr = st_reg.f.addr;
    end

    wch = st_reg.wr_addr[3];
    if (wr_prev & ~wr_act) begin
      unique case (st_reg.wr_addr[2:0])
        OFS_MODE1:  st_next.cfg[wch].m1     = dasp_mode1_t'(st_reg.wr_data);
        OFS_MODE2:  st_next.cfg[wch].m2     = dasp_mode2_t'(st_reg.wr_data);
        OFS_TX_DIV: st_next.cfg[wch].tx_div = st_reg.wr_data;
        OFS_RX_DIV: st_next.cfg[wch].rx_div = st_reg.wr_data;
        OFS_CMD: begin
          if (st_reg.wr_data[CMD_TX_ON]) begin
            st_next.cfg[wch].tx_en = 1'b1;
          end
          if (st_reg.wr_data[CMD_TX_OFF]) begin
            st_next.cfg[wch].tx_en = 1'b0;
          end
          if (st_reg.wr_data[CMD_RX_ON]) begin
            st_next.cfg[wch].rx_en = 1'b1;
          end
          if (st_reg.wr_data[CMD_RX_OFF]) begin
            st_next.cfg[wch].rx_en = 1'b0;
          end
          clr_err[wch] = st_reg.wr_data[CMD_CLR_ERR];
        end
        OFS_DATA:   tx_push[wch] = 1'b1;
        default: begin
        end
      endcase
    end

    // reading the data register releases the head character at strobe rise
    if (rd_prev & ~rd_act & (st_reg.rd_addr[2:0] == OFS_DATA)) begin
      rx_pop[st_reg.rd_addr[3]] = 1'b1;
    end

    for (int i = 0; i < 2; i++) begin
      status[i] = '{rx_addr_char: rx_valid[i] & rx_head[i].data[8],
                    frame_err:    rx_valid[i] & rx_head[i].frame_err,
                    parity_err:   rx_valid[i] & rx_head[i].parity_err,
                    overrun:      overrun[i],
                    tx_empty:     tx_empty[i],
                    tx_ready:     tx_ready[i],
                    rx_full:      rx_full[i],
                    rx_ready:     rx_valid[i]};
    end

    rch             = st_reg.f.addr[3];
    st_next.data_oe = rd_act;
    unique case (st_reg.f.addr[2:0])
      OFS_MODE1:   st_next.data_out = st_reg.cfg[rch].m1;
      OFS_MODE2:   st_next.data_out = st_reg.cfg[rch].m2;
      OFS_TX_DIV:  st_next.data_out = st_reg.cfg[rch].tx_div;
      OFS_RX_DIV:  st_next.data_out = st_reg.cfg[rch].rx_div;
      OFS_CMD:     st_next.data_out = status[rch];
      OFS_DATA:    st_next.data_out = rx_head[rch].data[7:0];
      OFS_IN_PORT: st_next.data_out = {4'h0, st_reg.f.ip3, 1'b0, st_reg.f.ip1, st_reg.f.ip0};
      default:     st_next.data_out = 8'h00;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg     <= '0;
      st_reg.s1  <= PINS_RST;
      st_reg.s2  <= PINS_RST;
      st_reg.s3  <= PINS_RST;
      st_reg.f   <= PINS_RST;
      st_reg.fd  <= PINS_RST;
      st_reg.cfg <= {CFG_RST, CFG_RST};
    end else begin
      st_reg <= st_next;
    end
  end

  for (genvar c = 0; c < 2; c++) begin : g_chan
    dasp_chan u_chan (
      .clock       (clock),
      .rst_n       (rst_n),
      .cfg         (st_reg.cfg[c]),
      .tx_push     (tx_push[c]),
      .tx_word     ({st_reg.cfg[c].m1.tx_addr_bit, st_reg.wr_data}),
      .tx_ready    (tx_ready[c]),
      .tx_empty    (tx_empty[c]),
      .rx_pop      (rx_pop[c]),
      .rx_valid    (rx_valid[c]),
      .rx_full     (rx_full[c]),
      .rx_head     (rx_head[c]),
      .overrun     (overrun[c]),
      .clr_err     (clr_err[c]),
      .tx_ext_ok   (tx_ext_ok[c]),
      .tx_ext_fall (tx_ext_fall[c]),
      .rx_ext_ok   (rx_ext_ok[c]),
      .rx_ext_rise (rx_ext_rise[c]),
      .serial_in   (serial_in[c]),
      .cts_n       (cts_n[c]),
      .serial_out  (serial_out[c])
    );
  end
endmodule

// File: tb/dasp_line_peer.sv
// serial peer: a crossed cable from each channel's output to the other's input
module dasp_line_peer (
  input  wire logic a_out,
  input  wire logic b_out,
  output      logic a_in,
  output      logic b_in
);
  timeunit 1ns;
  timeprecision 1ns;
  assign a_in = b_out;
  assign b_in = a_out;
endmodule

// File: tb/dasp_top_properties.sv
// checker on the host port and serial lines of dasp_top
module dasp_top_properties (
  input wire logic clock,
  input wire logic nrst,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic data_oe,
  input wire logic chan_a_serial_out,
  input wire logic chan_b_serial_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  cs_idle_a: assert property (chip_select_n [*8] |-> !data_oe) else $error("bus driven unselected");
  rd_idle_a: assert property (read_strobe_n [*8] |-> !data_oe) else $error("bus driven no read");
  rd_on_a: assert property ((!chip_select_n && !read_strobe_n) [*8] |-> data_oe) else $error("read not driven");
  oe_rise_a: assert property ($rose(data_oe) |-> $past(!chip_select_n && !read_strobe_n, 3)) else $error("early drive");
  oe_fall_a: assert property ($fell(data_oe) |-> $past(chip_select_n || read_strobe_n, 3)) else $error("early release");
  a_start_a: assert property ($fell(chan_a_serial_out) |-> !chan_a_serial_out [*8]) else $error("short low on a");
  b_start_a: assert property ($fell(chan_b_serial_out) |-> !chan_b_serial_out [*8]) else $error("short low on b");
  a_mark_a: assert property ($rose(chan_a_serial_out) |-> chan_a_serial_out [*8]) else $error("short high on a");
endmodule
bind dasp_top dasp_top_properties chk (.clock(clock), .nrst(nrst), .chip_select_n(chip_select_n),
  .read_strobe_n(read_strobe_n), .data_oe(data_oe), .chan_a_serial_out(chan_a_serial_out),
  .chan_b_serial_out(chan_b_serial_out));

// File: tb/test_dasp_top.sv
// testbench of dasp_top: register accesses and a character across the cable
module test_dasp_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clock = 0, nrst = 0, cs_n = 1, rd_n = 1, wr_n = 1, ip0 = 1, ip1 = 1;
  logic [3:0] addr = '0;
  logic [7:0] din = '0, v;
  logic [9:0] f;
  wire logic [7:0] dout;
  wire logic  oe, a_out, b_out, a_in, b_in;
  int         n_mismatch = 0, samples_checked = 0;
  logic       xrun = 0, xclk = 0;
  always #20 clock = ~clock;
  // shared external bit clock, 16 system clocks a period; rests low while xrun is low
  always begin
    repeat (8) @(negedge clock);
    xclk = xrun & ~xclk;
  end
  dasp_top dut (.clock(clock), .nrst(nrst), .bus_style(1'b0), .chip_select_n(cs_n), .read_strobe_n(rd_n),
    .write_strobe_n(wr_n), .reg_addr(addr), .data_in(din), .data_out(dout), .data_oe(oe),
    .input_port_bit0(ip0), .input_port_bit1(ip1), .input_port_bit3(xclk), .chan_a_serial_in(a_in),
    .chan_b_serial_in(b_in), .chan_b_ext_rx_clock(xclk), .chan_b_ext_tx_clock(xclk),
    .chan_a_serial_out(a_out), .chan_b_serial_out(b_out));
  dasp_line_peer peer (.a_out(a_out), .b_out(b_out), .a_in(a_in), .b_in(b_in));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clock);
    addr = a; din = d; cs_n = 0; wr_n = 0;
    repeat (8) @(negedge clock);
    wr_n = 1; cs_n = 1;
    repeat (8) @(negedge clock);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge clock);
    addr = a; cs_n = 0; rd_n = 0;
    repeat (8) @(negedge clock);
    d = dout;
    check({7'h0, oe}, 8'h01);
    rd_n = 1; cs_n = 1;
    repeat (8) @(negedge clock);
  endtask
  task automatic summarize;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #400000 n_mismatch++;
    summarize();
  end
  initial begin
    repeat (8) @(negedge clock);
    nrst = 1;
    repeat (10) @(negedge clock);
    rd(4'h0, v); check(v, 8'h00);
    rd(4'h2, v); check(v, 8'h0c);
    rd(4'h7, v); check(v, 8'h00);
    ip1 = 0;
    rd(4'h6, v); check(v, 8'h01);
    wr(4'h0, 8'h80);
    rd(4'h0, v); check(v, 8'h80);
    rd(4'h8, v); check(v, 8'h00);
    $display("test registers done");
    wr(4'h2, 8'h00); wr(4'hb, 8'h00); wr(4'hc, 8'h04); wr(4'h4, 8'h01);
    fork
      wr(4'h5, 8'ha5);
      begin
        @(negedge a_out);
        repeat (8) @(negedge clock);
        for (int k = 0; k < 10; k++) begin
          f[k] = a_out;
          repeat (16) @(negedge clock);
        end
      end
    join
    check(f[8:1], 8'ha5);
    check({6'h0, f[9], f[0]}, 8'h02);
    repeat (20) @(negedge clock);
    rd(4'hc, v); check({7'h0, v[0]}, 8'h01);
    rd(4'hd, v); check(v, 8'ha5);
    check({7'h0, a_out}, 8'h01);
    $display("test cable done");
    xrun = 1;
    wr(4'h8, 8'hb0);
    wr(4'h9, 8'h30);
    wr(4'hc, 8'h01);
    wr(4'h0, 8'h90);
    wr(4'h1, 8'h10);
    wr(4'h3, 8'h00);
    wr(4'h4, 8'h04);
    wr(4'hd, 8'h5a);
    wr(4'h5, 8'hc3);
    repeat (240) @(negedge clock);
    rd(4'hc, v);
    check(v, 8'h0d);
    rd(4'hd, v);
    check(v, 8'hc3);
    rd(4'h4, v);
    check(v, 8'h8d);
    rd(4'h5, v);
    check(v, 8'h5a);
    xrun = 0;
    $display("test external clocks done");
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h02);
    wr(4'h5, 8'h3c);
    for (int k = 0; k < 12; k++) begin
      repeat (16) @(negedge clock);
      check({7'h0, a_out}, 8'h01);
    end
    rd(4'h5, v);
    check(v, 8'h3c);
    $display("test local loop done");
    summarize();
  end
endmodule
